// ### rtl/dcb_cfg_top.sv
// Clock generation and receiver configuration register bank behind an AHB-Lite slave.
//
// Operation
// [R01] Source select 1: LVDS clock is channel A HS clock divided per divider field.
// [R02] Host writes divider zero when reference clock is the source.
// [R03] Divider code 0 passes clock; code n-1 divides by n, up to 25.
// [R04] Host never programs divider codes 25 to 31.
// [R05] Source select 0: LVDS clock is reference clock times multiplier field.
// [R06] Host writes multiplier zero when channel A clock is the source.
// [R07] Multiplier codes 0..3 multiply by 1..4; reset value is zero.
// [R08] PLL enable bit starts clock generation with current settings; reset disabled.
// [R09] Host disables PLL before changing source, divider or multiplier.
// [R10] Host keeps the chosen source clock running before enabling PLL.
// [R11] Pixel arrangement bit: 0 odd/even, 1 left/right halves.
// [R12] Channel mode: 00 dual, 01 single (reset), 10 two singles, 11 reserved.
// [R13] Channel A lane count: 00 four, 01 three, 10 two, 11 one (reset).
// [R14] Channel B lane count uses the same encoding, reset one lane.
// [R15] Leader strict bit clear tolerates one bit error; set tolerates none.
// [R16] Equalizer fields: 00 none, 01 1 dB, 11 2 dB, 10 reserved.
// [R17] Host programs channel A band in 5 MHz steps from code 8.
// [R18] Host programs channel B band with the same encoding.
// [R19] Source select bit: 0 reference clock (reset), 1 channel A HS clock.
// [R20] Host waits 3 ms after enable before relying on the LVDS clock.
// [R21] Every field reads back its last write and resets to its default.
// [R22] Clock generation keeps settings captured at enable while the PLL runs.
// [R23] Lanes not enabled by the lane counts are ignored.
// [R24] Reserved codes are stored, and their writes are flagged.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps

module dcb_cfg_top #(
  parameter int HADDR_W  = 10,  // Address bits decoded
  parameter int PERIOD_W = 16   // Width of the reference period counter
) (
  input  wire logic                 hclk,              // System clock, 100 MHz
  input  wire logic                 hresetn,           // Asynchronous reset, active low
  input  wire logic                 hsel,              // Slave select
  input  wire logic [HADDR_W-1:0]   haddr,             // Byte address
  input  wire logic [1:0]           htrans,            // Transfer type
  input  wire logic                 hwrite,            // Write when high
  input  wire logic [2:0]           hsize,             // Transfer size, word only
  input  wire logic [31:0]          hwdata,            // Write data
  input  wire logic                 hready,            // Bus ready
  output logic                      hreadyout,         // Slave ready
  output logic                      hresp,             // Always OKAY
  output logic [31:0]               hrdata,            // Read data
  input  wire logic                 ref_clk_pin,       // External reference clock pin
  input  wire logic                 chan_a_hs_clk_pin, // Channel A HS continuous clock pin
  input  wire logic [3:0]           chan_a_lane_act,   // Channel A lane activity
  input  wire logic [3:0]           chan_b_lane_act,   // Channel B lane activity
  output logic                      lvds_clk_tick,     // LVDS pixel clock enable pulse
  output logic                      pll_running,       // PLL enabled state
  output dcb_pkg::dcb_rx_cfg_s      rx_cfg,            // Receiver configuration
  output logic [3:0]                lane_a_used,       // Channel A activity on enabled lanes
  output logic [3:0]                lane_b_used,       // Channel B activity on enabled lanes
  output logic                      reserved_code_write // Pulse on reserved-code write
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  dcb_pkg::dcb_ahb_e    ahb_state_q;
  logic                 wr_pend_q;
  logic [7:0]           wr_idx_q;
  logic [7:0]           rd_idx_q;
  logic [31:0]          hrdata_q;
  logic                 acc;
  logic                 rd_acc;
  logic [7:0]           acc_idx;

  assign acc     = hsel && hready && htrans[1];
  assign rd_acc  = acc && !hwrite;
  assign acc_idx = haddr[9:2];

  // Reads take one wait state so that a write in the previous data phase is always visible.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ahb_state_q <= dcb_pkg::DCB_AHB_IDLE;
    else
    begin
      case (ahb_state_q)
        dcb_pkg::DCB_AHB_IDLE:  ahb_state_q <= rd_acc ? dcb_pkg::DCB_AHB_RWAIT
                                                      : dcb_pkg::DCB_AHB_IDLE;
        dcb_pkg::DCB_AHB_RWAIT: ahb_state_q <= dcb_pkg::DCB_AHB_RDONE;
        dcb_pkg::DCB_AHB_RDONE: ahb_state_q <= rd_acc ? dcb_pkg::DCB_AHB_RWAIT
                                                      : dcb_pkg::DCB_AHB_IDLE;
        default:                ahb_state_q <= dcb_pkg::DCB_AHB_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
      rd_idx_q  <= 8'h00;
    end
    else
    begin
      wr_pend_q <= acc && hwrite;
      if (acc)
      begin
        wr_idx_q <= acc_idx;
        rd_idx_q <= acc_idx;
      end
    end
  end

  assign hreadyout = (ahb_state_q != dcb_pkg::DCB_AHB_RWAIT);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic       clk_src_q;
  logic [4:0] div_q;
  logic [1:0] mult_q;
  logic       pll_en_q;
  logic [7:0] lane_q;
  logic [7:0] eq_q;
  logic [7:0] band_a_q;
  logic [7:0] band_b_q;
  logic [7:0] wb;

  assign wb = hwdata[7:0];

  // [R21] stored fields
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_src_q <= dcb_pkg::CLK_SRC_RST;
      div_q     <= dcb_pkg::DIVMUL_RST[7:3];
      mult_q    <= dcb_pkg::DIVMUL_RST[1:0];
      pll_en_q  <= dcb_pkg::PLL_RST;
      lane_q    <= dcb_pkg::LANE_RST;
      eq_q      <= dcb_pkg::EQ_RST;
      band_a_q  <= dcb_pkg::BAND_RST;
      band_b_q  <= dcb_pkg::BAND_RST;
    end
    else if (wr_pend_q)
    begin
      case (wr_idx_q)
        dcb_pkg::CLK_SRC_IDX: clk_src_q <= wb[0];
        dcb_pkg::DIVMUL_IDX:
        begin
          div_q  <= wb[dcb_pkg::DIV_LSB +: 5];
          mult_q <= wb[dcb_pkg::MULT_LSB +: 2];
        end
        dcb_pkg::PLL_IDX:     pll_en_q <= wb[0];
        dcb_pkg::LANE_IDX:    lane_q   <= wb;
        dcb_pkg::EQ_IDX:      eq_q     <= wb;
        dcb_pkg::BAND_A_IDX:  band_a_q <= wb;
        dcb_pkg::BAND_B_IDX:  band_b_q <= wb;
        default:              pll_en_q <= pll_en_q;
      endcase
    end
  end

  function automatic logic [7:0] read_mux(input logic [7:0] idx);
    case (idx)
      dcb_pkg::CLK_SRC_IDX: read_mux = {7'h00, clk_src_q};
      dcb_pkg::DIVMUL_IDX:  read_mux = {div_q, 1'b0, mult_q};
      dcb_pkg::PLL_IDX:     read_mux = {7'h00, pll_en_q};
      dcb_pkg::LANE_IDX:    read_mux = lane_q;
      dcb_pkg::EQ_IDX:      read_mux = eq_q;
      dcb_pkg::BAND_A_IDX:  read_mux = band_a_q;
      dcb_pkg::BAND_B_IDX:  read_mux = band_b_q;
      dcb_pkg::STATUS_IDX:  read_mux = {7'h00, pll_running};
      default:              read_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h00000000;
    else if (ahb_state_q == dcb_pkg::DCB_AHB_RWAIT)
      hrdata_q <= {24'h000000, read_mux(rd_idx_q)};
  end

  // [R24] flag reserved codes
  logic rsvd_w;
  always_comb
  begin
    rsvd_w = 1'b0;
    case (wr_idx_q)
      dcb_pkg::DIVMUL_IDX: rsvd_w = (wb[7:3] > dcb_pkg::DIV_MAX_CODE);
      dcb_pkg::LANE_IDX:   rsvd_w = (wb[6:5] == dcb_pkg::CHMODE_RSVD);
      dcb_pkg::EQ_IDX:     rsvd_w = (wb[7:6] == dcb_pkg::EQ_RSVD) || (wb[5:4] == dcb_pkg::EQ_RSVD)
                                 || (wb[3:2] == dcb_pkg::EQ_RSVD) || (wb[1:0] == dcb_pkg::EQ_RSVD);
      dcb_pkg::BAND_A_IDX: rsvd_w = (wb < dcb_pkg::BAND_MIN);
      dcb_pkg::BAND_B_IDX: rsvd_w = (wb < dcb_pkg::BAND_MIN);
      default:             rsvd_w = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      reserved_code_write <= 1'b0;
    else
      reserved_code_write <= wr_pend_q && rsvd_w;
  end

  // ****************************************************************
  // Receiver configuration
  // ****************************************************************
  function automatic logic [3:0] lane_mask(input logic [1:0] code);
    case (code)
      2'h0:    lane_mask = 4'hF;
      2'h1:    lane_mask = 4'h7;
      2'h2:    lane_mask = 4'h3;
      default: lane_mask = 4'h1;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rx_cfg <= '0;
    else
    begin
      // [R11] pixel arrangement
      rx_cfg.left_right    <= lane_q[dcb_pkg::LR_POS];
      // [R12] channel mode
      rx_cfg.chan_mode     <= lane_q[dcb_pkg::CHMODE_LSB +: 2];
      // [R13] lane count A
      rx_cfg.lane_en_a     <= lane_mask(lane_q[dcb_pkg::LANE_A_LSB +: 2]);
      // [R14] lane count B
      rx_cfg.lane_en_b     <= lane_mask(lane_q[dcb_pkg::LANE_B_LSB +: 2]);
      // [R15] leader tolerance
      rx_cfg.leader_strict <= lane_q[dcb_pkg::STRICT_POS];
      // [R16] equalizer codes
      rx_cfg.eq_data_a     <= eq_q[dcb_pkg::EQ_DA_LSB +: 2];
      rx_cfg.eq_data_b     <= eq_q[dcb_pkg::EQ_DB_LSB +: 2];
      rx_cfg.eq_clk_a      <= eq_q[dcb_pkg::EQ_CA_LSB +: 2];
      rx_cfg.eq_clk_b      <= eq_q[dcb_pkg::EQ_CB_LSB +: 2];
      rx_cfg.band_a        <= band_a_q;
      rx_cfg.band_b        <= band_b_q;
    end
  end

  // Lane activity arrives from the analog front end on another timing, so it is synchronised.
  logic [3:0] la_s1_q;
  logic [3:0] la_s2_q;
  logic [3:0] la_s3_q;
  logic [3:0] la_lvl_q;
  logic [3:0] lb_s1_q;
  logic [3:0] lb_s2_q;
  logic [3:0] lb_s3_q;
  logic [3:0] lb_lvl_q;

  // A bit moves only once the second and third stages agree, so a glitch is not seen.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      la_s1_q     <= 4'h0;
      la_s2_q     <= 4'h0;
      la_s3_q     <= 4'h0;
      la_lvl_q    <= 4'h0;
      lb_s1_q     <= 4'h0;
      lb_s2_q     <= 4'h0;
      lb_s3_q     <= 4'h0;
      lb_lvl_q    <= 4'h0;
      lane_a_used <= 4'h0;
      lane_b_used <= 4'h0;
    end
    else
    begin
      la_s1_q  <= chan_a_lane_act;
      la_s2_q  <= la_s1_q;
      la_s3_q  <= la_s2_q;
      la_lvl_q <= (la_s2_q & la_s3_q) | (la_lvl_q & (la_s2_q | la_s3_q));
      lb_s1_q  <= chan_b_lane_act;
      lb_s2_q  <= lb_s1_q;
      lb_s3_q  <= lb_s2_q;
      lb_lvl_q <= (lb_s2_q & lb_s3_q) | (lb_lvl_q & (lb_s2_q | lb_s3_q));
      // [R23] disabled lanes ignored
      lane_a_used <= la_lvl_q & rx_cfg.lane_en_a;
      lane_b_used <= lb_lvl_q & rx_cfg.lane_en_b;
    end
  end

  // ****************************************************************
  // Clock source sampling
  // ****************************************************************
  logic [1:0] pin_in;
  logic [1:0] src_tick;

  assign pin_in = {chan_a_hs_clk_pin, ref_clk_pin};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_src
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      logic lvl_prev_q;
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          s1_q       <= 1'b0;
          s2_q       <= 1'b0;
          s3_q       <= 1'b0;
          lvl_q      <= 1'b0;
          lvl_prev_q <= 1'b0;
        end
        else
        begin
          s1_q       <= pin_in[g];
          s2_q       <= s1_q;
          s3_q       <= s2_q;
          lvl_prev_q <= lvl_q;
          if (s2_q == s3_q)
            lvl_q <= s3_q;
        end
      end
      assign src_tick[g] = lvl_q && !lvl_prev_q;
    end
  endgenerate

  // ****************************************************************
  // Clock generation
  // ****************************************************************
  dcb_pkg::dcb_clk_set_s shadow_q;
  logic [4:0]            div_cnt_q;
  logic [PERIOD_W-1:0]   per_cnt_q;
  logic [PERIOD_W-1:0]   period_q;
  logic [PERIOD_W:0]     mul_acc_q;
  logic [PERIOD_W:0]     mul_sum;
  logic                  mul_hit;
  logic                  div_hit;

  assign pll_running = pll_en_q;

  // [R08] enable captures live settings
  // [R22] held while running
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      shadow_q <= '0;
    else if (!pll_en_q)
      shadow_q <= '{src: clk_src_q, div: div_q, mult: mult_q};
  end

  // [R19] source select
  // [R01] channel A divide
  // [R03] code n-1 divides by n
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_cnt_q <= 5'h00;
    else if (!pll_en_q || !shadow_q.src)
      div_cnt_q <= 5'h00;
    else if (src_tick[1])
      div_cnt_q <= div_hit ? 5'h00 : div_cnt_q + 5'h01;
  end

  assign div_hit = (div_cnt_q >= shadow_q.div);

  // Reference period is measured in system clocks; the multiplied clock cannot exceed hclk.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      per_cnt_q <= '0;
      period_q  <= '0;
    end
    else if (src_tick[0])
    begin
      per_cnt_q <= '0;
      period_q  <= per_cnt_q + 1'b1;
    end
    else if (per_cnt_q != '1)
      per_cnt_q <= per_cnt_q + 1'b1;
  end

  // [R05] reference multiply
  // [R07] factor is code plus one
  assign mul_sum = mul_acc_q + {{(PERIOD_W-2){1'b0}}, 1'b0, shadow_q.mult} + 1'b1;
  assign mul_hit = (period_q != '0) && (mul_sum >= {1'b0, period_q});

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mul_acc_q <= '0;
    else if (!pll_en_q || shadow_q.src)
      mul_acc_q <= '0;
    else if (period_q != '0)
      mul_acc_q <= mul_hit ? mul_sum - {1'b0, period_q} : mul_sum;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lvds_clk_tick <= 1'b0;
    else
      lvds_clk_tick <= pll_en_q && (shadow_q.src ? (src_tick[1] && div_hit) : mul_hit);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_read_wait: assert property (rd_acc |=> !hreadyout ##1 hreadyout) // [R21]
    else $error("Read wait state not one cycle");
  a_write_store: assert property ((acc && hwrite && acc_idx == dcb_pkg::LANE_IDX)
                                  |=> ##1 lane_q == $past(hwdata[7:0])) // [R21]
    else $error("Lane register did not store write");
  a_readback: assert property ((rd_acc && acc_idx == dcb_pkg::BAND_A_IDX)
                               |=> ##1 hrdata[7:0] == band_a_q) // [R21]
    else $error("Band A readback wrong");
  a_unmapped_zero: assert property ((rd_acc && acc_idx == 8'h00) |=> ##1 hrdata == 32'h0)
    else $error("Unmapped read not zero");
  a_shadow_hold: assert property (pll_en_q && $past(pll_en_q) |-> $stable(shadow_q)) // [R22]
    else $error("Clock settings changed while running");
  a_capture_live: assert property ($rose(pll_en_q) |-> shadow_q.div == div_q
                                   && shadow_q.mult == mult_q) // [R08]
    else $error("Enable did not capture settings");
  a_idle_no_tick: assert property (!pll_en_q |=> !lvds_clk_tick) // [R08]
    else $error("Clock pulse while disabled");
  a_div_pass: assert property ((pll_en_q && shadow_q.src && shadow_q.div == 5'h00
                                && src_tick[1]) |=> lvds_clk_tick) // [R03]
    else $error("Undivided source tick lost");
  a_div_two: assert property ((pll_en_q && $past(pll_en_q) && shadow_q.src
                               && shadow_q.div == 5'h01 && lvds_clk_tick)
                              |-> div_cnt_q == 5'h00) // [R01]
    else $error("Divide by two count wrong");
  a_rsvd_flag: assert property ((acc && hwrite && acc_idx == dcb_pkg::LANE_IDX)
                                ##1 (hwdata[6:5] == 2'h3) |=> reserved_code_write) // [R24]
    else $error("Reserved channel mode not flagged");
  a_lane_gate: assert property (!rx_cfg.lane_en_a[3] && $past(!rx_cfg.lane_en_a[3])
                                |=> !lane_a_used[3]) // [R23]
    else $error("Disabled lane reported active");

  c_pll_start:  cover property ($rose(pll_en_q));
  c_chan_tick:  cover property (lvds_clk_tick && shadow_q.src);
  c_ref_tick:   cover property (lvds_clk_tick && !shadow_q.src);
  c_rsvd_write: cover property (reserved_code_write);

endmodule

// ### rtl/dcb_pkg.sv
// Shared constants, register map and carrier types for the bridge clock/receiver config block.
package dcb_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam int        IDX_W          = 8;
  localparam logic [7:0] CLK_SRC_IDX   = 8'h0A;
  localparam logic [7:0] DIVMUL_IDX    = 8'h0B;
  localparam logic [7:0] PLL_IDX       = 8'h0D;
  localparam logic [7:0] LANE_IDX      = 8'h10;
  localparam logic [7:0] EQ_IDX        = 8'h11;
  localparam logic [7:0] BAND_A_IDX    = 8'h12;
  localparam logic [7:0] BAND_B_IDX    = 8'h13;
  localparam logic [7:0] STATUS_IDX    = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DIV_LSB      = 3;
  localparam int MULT_LSB     = 0;
  localparam int LR_POS       = 7;
  localparam int CHMODE_LSB   = 5;
  localparam int LANE_A_LSB   = 3;
  localparam int LANE_B_LSB   = 1;
  localparam int STRICT_POS   = 0;
  localparam int EQ_DA_LSB    = 6;
  localparam int EQ_DB_LSB    = 4;
  localparam int EQ_CA_LSB    = 2;
  localparam int EQ_CB_LSB    = 0;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic       CLK_SRC_RST  = 1'b0;
  localparam logic [7:0] DIVMUL_RST   = 8'h00;
  localparam logic       PLL_RST      = 1'b0;
  localparam logic [7:0] LANE_RST     = 8'h3E;
  localparam logic [7:0] EQ_RST       = 8'h00;
  localparam logic [7:0] BAND_RST     = 8'h00;
  localparam logic [4:0] DIV_MAX_CODE = 5'h18;
  localparam logic [1:0] CHMODE_RSVD  = 2'h3;
  localparam logic [1:0] EQ_RSVD      = 2'h2;
  localparam logic [7:0] BAND_MIN     = 8'h08;

  typedef enum logic [1:0] {
    DCB_AHB_IDLE  = 2'b00,
    DCB_AHB_RWAIT = 2'b01,
    DCB_AHB_RDONE = 2'b11
  } dcb_ahb_e;

  typedef struct packed {
    logic       src;
    logic [4:0] div;
    logic [1:0] mult;
  } dcb_clk_set_s;

  typedef struct packed {
    logic       left_right;
    logic [1:0] chan_mode;
    logic [3:0] lane_en_a;
    logic [3:0] lane_en_b;
    logic       leader_strict;
    logic [1:0] eq_data_a;
    logic [1:0] eq_data_b;
    logic [1:0] eq_clk_a;
    logic [1:0] eq_clk_b;
    logic [7:0] band_a;
    logic [7:0] band_b;
  } dcb_rx_cfg_s;

endpackage

// ### testbench/dsi_bridge_clock_rx_config_test.sv
// Self-checking testbench for the bridge clock and receiver configuration block.
`timescale 1ns/1ps

module dsi_bridge_clock_rx_config_test;
  logic                 hclk = 1'b0;
  logic                 hresetn = 1'b0;
  logic                 hsel = 1'b0;
  logic [9:0]           haddr = 10'h000;
  logic [1:0]           htrans = 2'h0;
  logic                 hwrite = 1'b0;
  logic [31:0]          hwdata = 32'h0;
  logic                 hreadyout;
  logic                 hresp;
  logic [31:0]          hrdata;
  logic                 ref_clk_pin = 1'b0;
  logic                 hs_pin = 1'b0;
  logic [3:0]           act_a = 4'h0;
  logic [3:0]           act_b = 4'h0;
  logic                 lvds_clk_tick;
  logic                 pll_running;
  dcb_pkg::dcb_rx_cfg_s rx_cfg;
  logic [3:0]           lane_a_used;
  logic [3:0]           lane_b_used;
  logic                 reserved_code_write;
  logic [31:0]          rdata;
  int                   n_fail = 0;
  int                   checks = 0;
  int                   n_tick = 0;
  int                   n_rsv = 0;

  dcb_cfg_top #(.HADDR_W(10), .PERIOD_W(16)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_clk_pin(ref_clk_pin),
    .chan_a_hs_clk_pin(hs_pin), .chan_a_lane_act(act_a), .chan_b_lane_act(act_b),
    .lvds_clk_tick(lvds_clk_tick), .pll_running(pll_running), .rx_cfg(rx_cfg),
    .lane_a_used(lane_a_used), .lane_b_used(lane_b_used),
    .reserved_code_write(reserved_code_write)
  );

  always #5 hclk = ~hclk;

  // Reference clock runs free with a period of 40 cycles, well below hclk/8.
  // reference always running
  always
  begin
    repeat (20) @(posedge hclk);
    ref_clk_pin <= ~ref_clk_pin;
  end

  always @(posedge hclk)
  begin
    if (lvds_clk_tick === 1'b1) n_tick++;
    if (reserved_code_write === 1'b1) n_rsv++;
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_near(input int got, input int exp, input int tol, input string what);
    checks++;
    if (got < exp - tol || got > exp + tol)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // The master looks at hready just before the edge, as nothing changes in between.
  task automatic wait_ready();
    do @(negedge hclk); while (hready_ok() == 0);
    rdata = hrdata;
    @(posedge hclk);
  endtask

  function automatic bit hready_ok();
    return hreadyout === 1'b1;
  endfunction

  task automatic bus_xfer(input logic [7:0] idx, input logic wr, input logic [7:0] val);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, val};
    wait_ready();
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    bus_xfer(idx, 1'b0, 8'h00);
    check_val(rdata, exp, what);
  endtask

  task automatic pulse_hs(input int n);
    @(posedge hclk);
    repeat (n)
    begin
      hs_pin <= 1'b1;
      repeat (10) @(posedge hclk);
      hs_pin <= 1'b0;
      repeat (10) @(posedge hclk);
    end
  endtask

  task automatic tick_run(input int edges, input int exp, input int tol, input string what);
    int t0;
    @(negedge hclk);
    t0 = n_tick;
    if (edges > 0) pulse_hs(edges);
    else repeat (180) @(posedge hclk);
    repeat (20) @(posedge hclk);
    @(negedge hclk);
    check_near(n_tick - t0, exp, tol, what);
  endtask

  task automatic test_reset();
    rd_chk(dcb_pkg::CLK_SRC_IDX, 32'h00, "source select");
    rd_chk(dcb_pkg::DIVMUL_IDX, 32'h00, "divider multiplier");
    rd_chk(dcb_pkg::PLL_IDX, 32'h00, "pll enable");
    rd_chk(dcb_pkg::LANE_IDX, 32'h3E, "lane config");
    rd_chk(dcb_pkg::EQ_IDX, 32'h00, "equalizer");
    rd_chk(dcb_pkg::BAND_A_IDX, 32'h00, "band a");
    rd_chk(dcb_pkg::BAND_B_IDX, 32'h00, "band b");
    check_val(32'(rx_cfg.chan_mode), 32'h1, "default mode");
    check_val(32'({rx_cfg.lane_en_a, rx_cfg.lane_en_b}), 32'h11, "default lanes");
    check_val(32'({pll_running, hresp}), 32'h0, "pll idle");
    $display("test reset done");
  endtask

  task automatic test_rw();
    logic [7:0] idx [7] = '{8'h0A, 8'h0B, 8'h10, 8'h11, 8'h12, 8'h13, 8'h00};
    logic [7:0] wv [7] = '{8'hFF, 8'hC0, 8'h81, 8'hDD, 8'h08, 8'h09, 8'h5A};
    logic [7:0] ev [7] = '{8'h01, 8'hC0, 8'h81, 8'hDD, 8'h08, 8'h09, 8'h00};
    int r0;
    r0 = n_rsv;
    for (int i = 0; i < 7; i++) bus_xfer(idx[i], 1'b1, wv[i]);
    for (int i = 0; i < 7; i++) rd_chk(idx[i], 32'(ev[i]), "readback");
    check_val(32'({rx_cfg.left_right, rx_cfg.chan_mode}), 32'h4, "left right dual");
    check_val(32'(rx_cfg.leader_strict), 32'h1, "strict leader");
    check_val(32'({rx_cfg.eq_data_a, rx_cfg.eq_data_b, rx_cfg.eq_clk_a, rx_cfg.eq_clk_b}),
              32'hDD, "equalizers");
    check_val(32'(rx_cfg.band_a), 32'h08, "band a");
    check_val(32'(rx_cfg.band_b), 32'h09, "band b");
    check_near(n_rsv - r0, 0, 0, "legal codes flagged");
    $display("test readback done");
  endtask

  task automatic test_reserved();
    logic [7:0] idx [8] = '{8'h0B, 8'h10, 8'h11, 8'h11, 8'h11, 8'h11, 8'h12, 8'h13};
    logic [7:0] wv [8] = '{8'hC8, 8'h7E, 8'h80, 8'h20, 8'h08, 8'h02, 8'h07, 8'h00};
    int r0;
    for (int i = 0; i < 8; i++)
    begin
      r0 = n_rsv;
      bus_xfer(idx[i], 1'b1, wv[i]);
      repeat (3) @(posedge hclk);
      @(negedge hclk);
      check_near(n_rsv - r0, 1, 0, "reserved flag");
      rd_chk(idx[i], 32'(wv[i]), "reserved stored");
    end
    $display("test reserved done");
  endtask

  task automatic test_lanes();
    logic [3:0] m;
    act_a <= 4'hF;
    act_b <= 4'hA;
    for (int c = 0; c < 4; c++)
    begin
      bus_xfer(dcb_pkg::LANE_IDX, 1'b1, 8'(8'h20 | (c << 3) | (c << 1)));
      repeat (4) @(posedge hclk);
      @(negedge hclk);
      m = 4'(4'hF >> c);
      check_val(32'(rx_cfg.lane_en_a), 32'(m), "lanes a");
      check_val(32'(rx_cfg.lane_en_b), 32'(m), "lanes b");
      check_val(32'({lane_a_used, lane_b_used}), 32'({m, m & 4'hA}), "lane mask");
    end
    $display("test lanes done");
  endtask

  task automatic pll_set(input logic [7:0] divmul, input logic on);
    bus_xfer(dcb_pkg::PLL_IDX, 1'b1, 8'h00);
    bus_xfer(dcb_pkg::DIVMUL_IDX, 1'b1, divmul);
    bus_xfer(dcb_pkg::PLL_IDX, 1'b1, {7'h0, on});
  endtask

  task automatic test_divider();
    bus_xfer(dcb_pkg::CLK_SRC_IDX, 1'b1, 8'h01);
    pll_set(8'h10, 1'b1);
    rd_chk(dcb_pkg::STATUS_IDX, 32'h1, "pll status");
    tick_run(9, 3, 0, "divide by 3");
    bus_xfer(dcb_pkg::DIVMUL_IDX, 1'b1, 8'h00);
    tick_run(6, 2, 0, "settings frozen");
    pll_set(8'h00, 1'b0);
    tick_run(6, 0, 0, "pll off");
    pll_set(8'h00, 1'b1);
    tick_run(4, 4, 0, "undivided");
    pll_set(8'h08, 1'b1);
    tick_run(4, 2, 0, "divide by 2");
    pll_set(8'hC0, 1'b1);
    tick_run(24, 0, 0, "divide by 25 early");
    tick_run(1, 1, 0, "divide by 25");
    $display("test divider done");
  endtask

  task automatic test_multiplier();
    pll_set(8'h00, 1'b0);
    bus_xfer(dcb_pkg::CLK_SRC_IDX, 1'b1, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      pll_set(8'(m), 1'b1);
      repeat (80) @(posedge hclk);
      tick_run(0, 5 * (m + 1), 1, "multiplier");
    end
    $display("test multiplier done");
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_rw();
    test_reserved();
    test_lanes();
    test_divider();
    test_multiplier();
    give_verdict();
  end

  // The tests need about 2700 cycles; the limit of 30000 cycles leaves ample margin.
  initial
  begin
    #300000;
    n_fail++;
    $display("mismatch at %0t: run timed out", $time);
    give_verdict();
  end
endmodule
